// [rtl/msal_pkg.sv]
`default_nettype none
package msal_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] CFG_ONE_ADDR    = 8'h40;
  localparam logic [7:0] STATUS_ONE_ADDR = 8'h41;
  localparam logic [7:0] STATUS_TWO_ADDR = 8'h42;
  localparam logic [7:0] STATUS_THR_ADDR = 8'h43;
  localparam logic [7:0] MASK_ONE_ADDR   = 8'h74;
  localparam logic [7:0] MASK_TWO_ADDR   = 8'h75;
  localparam logic [7:0] CFG_THR_ADDR    = 8'h78;
  localparam logic [7:0] CFG_FOUR_ADDR   = 8'h7D;
  localparam logic [7:0] STATUS_FOU_ADDR = 8'h81;
  localparam logic [7:0] MASK_THR_ADDR   = 8'h82;
  localparam logic [7:0] MASK_FOU_ADDR   = 8'h83;
  localparam logic [7:0] VALUE_BASE_ADDR = 8'h20;

  // ---------------------------------------------------------------
  // Field positions and codes
  // ---------------------------------------------------------------
  localparam int          START_BIT        = 0;
  localparam int          PIN10_ALERT_BIT  = 0;
  localparam logic [1:0]  PIN14_ALERT_CODE = 2'h2;
  localparam int          CHAIN_ONE_BIT    = 7;
  localparam int          CHAIN_TWO_BIT    = 1;
  localparam int          CHAIN_THR_BIT    = 7;

  // Implemented status bits per status register (chain bits excluded)
  localparam logic [7:0]  SRC_ONE_MASK     = 8'h7F;
  localparam logic [7:0]  SRC_TWO_MASK     = 8'hFD;
  localparam logic [7:0]  SRC_THR_MASK     = 8'h0F;
  localparam logic [7:0]  SRC_FOU_MASK     = 8'hF8;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0]  CFG_ONE_RESET    = 8'h00;
  localparam logic [7:0]  CFG_THR_RESET    = 8'h00;
  localparam logic [7:0]  CFG_FOUR_RESET   = 8'h00;
  localparam logic [7:0]  MASK_RESET       = 8'h00;
  localparam logic [7:0]  VALUE_RESET      = 8'h00;

  // ---------------------------------------------------------------
  // Round-robin channels and conversion timing
  // ---------------------------------------------------------------
  localparam int          NUM_CHANNELS     = 10;
  localparam logic [3:0]  LAST_CHANNEL     = 4'h9;
  localparam logic [3:0]  CH_LOCAL         = 4'h7;
  localparam logic [3:0]  CH_REMOTE_ONE    = 4'h8;
  localparam logic [3:0]  CH_REMOTE_TWO    = 4'h9;
  localparam int          CLK_MHZ          = 250;
  localparam int          VOLT_TIME_MS     = 11;
  localparam int          LOCAL_TIME_MS    = 12;
  localparam int          REMOTE_TIME_MS   = 39;
  localparam int          VOLT_CYCLES      = VOLT_TIME_MS * 1000 * CLK_MHZ;
  localparam int          LOCAL_CYCLES     = LOCAL_TIME_MS * 1000 * CLK_MHZ;
  localparam int          REMOTE_CYCLES    = REMOTE_TIME_MS * 1000 * CLK_MHZ;
  localparam int          TIMER_WIDTH      = 24;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic {
    SEQ_IDLE,
    SEQ_RUN
  } msal_seq_type;

  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } msal_reg_req_type;

  // Out-of-limit levels from logic running beside the round-robin
  typedef struct packed {
    logic remote_diode_two_fault;
    logic remote_diode_one_fault;
    logic fan_four_or_hot_timer_flag;
    logic fan_three;
    logic fan_two;
    logic fan_one;
    logic overtemp_flag;
    logic cpu_link_error_a;
    logic cpu_link_data_error;
    logic cpu_sensor_zero_flag;
    logic cpu_sensor_three_flag;
    logic cpu_sensor_two_flag;
    logic cpu_sensor_one_flag;
  } msal_ext_type;

endpackage : msal_pkg
`default_nettype wire

// [rtl/msal_monitor_status_alert.sv]
// How it works
// - Start bit runs round-robin until cleared
// - Each finished conversion updates its value register
// - Ten channels: seven voltages, three temperatures
// - Conversion times 11, 12, 39 ms
// - Fan and CPU sources run independently
// - Out-of-limit result sets status bit
// - Sticky; read clears only when condition gone
// - Summary bits chain to next status register
// - Each status register paired with mask
// - Second status register bit layout fixed
// - Alert disabled after reset
// - Pin ten: alert or fan drive two
// - Alert low while unmasked status set
// - Mask blocks alert, not status
// - Every source individually maskable
// - Pin fourteen function select, code 10 alert
// - Above high or at/below low violates
`timescale 1ns/1ns
`default_nettype none
module msal_monitor_status_alert #(
  parameter int VOLT_CYCLES   = msal_pkg::VOLT_CYCLES,
  parameter int LOCAL_CYCLES  = msal_pkg::LOCAL_CYCLES,
  parameter int REMOTE_CYCLES = msal_pkg::REMOTE_CYCLES
) (
  input  wire logic                       clock_in,
  input  wire logic                       srst_in,
  input  wire msal_pkg::msal_reg_req_type reg_req_in,
  output logic [7:0]                      reg_rdata_out,
  input  wire logic [7:0]                 meas_value_in,
  input  wire logic [7:0]                 limit_high_in,
  input  wire logic [7:0]                 limit_low_in,
  input  wire msal_pkg::msal_ext_type     ext_flags_in,
  input  wire logic                       fan_drive_two_in,
  output logic [3:0]                      channel_sel_out,
  output logic                            single_channel_select_done_out,
  output logic                            pin10_out,
  output logic                            pin10_oe_out,
  output logic                            pin14_out,
  output logic                            pin14_oe_out
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [23:0] single_channel_select_cycles(input logic [3:0] ch);
    if (ch == msal_pkg::CH_REMOTE_ONE || ch == msal_pkg::CH_REMOTE_TWO)
      return 24'(REMOTE_CYCLES);
    else if (ch == msal_pkg::CH_LOCAL)
      return 24'(LOCAL_CYCLES);
    else
      return 24'(VOLT_CYCLES);
  endfunction

  // Status register index for an offset, 4 when not a status register
  function automatic logic [2:0] status_index(input logic [7:0] addr);
    unique case (addr)
      msal_pkg::STATUS_ONE_ADDR: return 3'h0;
      msal_pkg::STATUS_TWO_ADDR: return 3'h1;
      msal_pkg::STATUS_THR_ADDR: return 3'h2;
      msal_pkg::STATUS_FOU_ADDR: return 3'h3;
      default:                   return 3'h4;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  msal_pkg::msal_seq_type seq_r,      seq_nxt;
  logic [3:0]             chan_r,     chan_nxt;
  logic [23:0]            timer_r,    timer_nxt;
  logic                   done_r,     done_nxt;
  logic [7:0]             value_r     [msal_pkg::NUM_CHANNELS];
  logic [7:0]             value_nxt   [msal_pkg::NUM_CHANNELS];
  logic [7:0]             cond_r      [4];
  logic [7:0]             cond_nxt    [4];
  logic [7:0]             status_r    [4];
  logic [7:0]             status_nxt  [4];
  logic [7:0]             mask_r      [4];
  logic [7:0]             mask_nxt    [4];
  logic [7:0]             cfg_one_r,  cfg_one_nxt;
  logic [7:0]             cfg_thr_r,  cfg_thr_nxt;
  logic [7:0]             cfg_four_r, cfg_four_nxt;
  logic [7:0]             rdata_r,    rdata_nxt;
  logic                   p10_r,      p10_nxt;
  logic                   p10_oe_r,   p10_oe_nxt;
  logic                   p14_oe_r,   p14_oe_nxt;

  logic [7:0]             src_mask    [4];
  logic [7:0]             view        [4];
  logic                   oolimit;
  logic                   alert;
  logic [2:0]             rd_idx;

  assign src_mask[0] = msal_pkg::SRC_ONE_MASK;
  assign src_mask[1] = msal_pkg::SRC_TWO_MASK;
  assign src_mask[2] = msal_pkg::SRC_THR_MASK;
  assign src_mask[3] = msal_pkg::SRC_FOU_MASK;

  // ---------------------------------------------------------------
  // Round-robin sequencer
  // ---------------------------------------------------------------
  always_comb begin
    seq_nxt   = seq_r;
    chan_nxt  = chan_r;
    timer_nxt = timer_r;
    done_nxt  = 1'b0;
    value_nxt = value_r;
    oolimit   = (meas_value_in > limit_high_in) ||
                (meas_value_in <= limit_low_in);
    unique case (seq_r)
      msal_pkg::SEQ_IDLE: begin
        chan_nxt  = 4'h0;
        timer_nxt = 24'h000000;
        if (cfg_one_r[msal_pkg::START_BIT]) begin
          seq_nxt = msal_pkg::SEQ_RUN;
        end
      end
      msal_pkg::SEQ_RUN: begin
        if (!cfg_one_r[msal_pkg::START_BIT]) begin
          seq_nxt = msal_pkg::SEQ_IDLE;
        end else if (timer_r == single_channel_select_cycles(chan_r) - 24'h000001) begin
          done_nxt         = 1'b1;
          value_nxt[chan_r] = meas_value_in;
          timer_nxt        = 24'h000000;
          chan_nxt         = (chan_r == msal_pkg::LAST_CHANNEL) ?
                             4'h0 : chan_r + 4'h1;
        end else begin
          timer_nxt = timer_r + 24'h000001;
        end
      end
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      seq_r   <= msal_pkg::SEQ_IDLE;
      chan_r  <= 4'h0;
      timer_r <= 24'h000000;
      done_r  <= 1'b0;
      for (int i = 0; i < msal_pkg::NUM_CHANNELS; i++) begin
        value_r[i] <= msal_pkg::VALUE_RESET;
      end
    end else begin
      seq_r   <= seq_nxt;
      chan_r  <= chan_nxt;
      timer_r <= timer_nxt;
      done_r  <= done_nxt;
      value_r <= value_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Limit conditions and sticky status
  // ---------------------------------------------------------------
  always_comb begin
    cond_nxt   = cond_r;
    status_nxt = status_r;
    rd_idx     = status_index(reg_req_in.addr);
    if (seq_r == msal_pkg::SEQ_RUN && done_nxt) begin
      unique case (chan_r)
        4'h0: cond_nxt[0][0] = oolimit;
        4'h1: cond_nxt[0][1] = oolimit;
        4'h2: cond_nxt[0][2] = oolimit;
        4'h3: cond_nxt[0][3] = oolimit;
        4'h4: cond_nxt[1][0] = oolimit;
        4'h5: cond_nxt[3][7] = oolimit;
        4'h6: cond_nxt[3][6] = oolimit;
        4'h7: cond_nxt[0][5] = oolimit;
        4'h8: cond_nxt[0][4] = oolimit;
        4'h9: cond_nxt[0][6] = oolimit;
        default: ;
      endcase
    end
    cond_nxt[1][7:2] = {ext_flags_in.remote_diode_two_fault,
                        ext_flags_in.remote_diode_one_fault,
                        ext_flags_in.fan_four_or_hot_timer_flag,
                        ext_flags_in.fan_three,
                        ext_flags_in.fan_two,
                        ext_flags_in.fan_one};
    cond_nxt[2][3:0] = {ext_flags_in.overtemp_flag,
                        ext_flags_in.cpu_link_error_a,
                        ext_flags_in.cpu_link_data_error,
                        ext_flags_in.cpu_sensor_zero_flag};
    cond_nxt[3][5:3] = {ext_flags_in.cpu_sensor_three_flag,
                        ext_flags_in.cpu_sensor_two_flag,
                        ext_flags_in.cpu_sensor_one_flag};
    for (int i = 0; i < 4; i++) begin
      if (reg_req_in.rd && rd_idx == 3'(i)) begin
        status_nxt[i] = status_r[i] & cond_nxt[i];
      end
      status_nxt[i] = (status_nxt[i] | cond_nxt[i]) & src_mask[i];
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      for (int i = 0; i < 4; i++) begin
        cond_r[i]   <= 8'h00;
        status_r[i] <= 8'h00;
      end
    end else begin
      cond_r   <= cond_nxt;
      status_r <= status_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Summary chain and read view
  // ---------------------------------------------------------------
  always_comb begin
    view[3] = status_r[3];
    view[2] = status_r[2];
    view[2][msal_pkg::CHAIN_THR_BIT] = |view[3];
    view[1] = status_r[1];
    view[1][msal_pkg::CHAIN_TWO_BIT] = |view[2];
    view[0] = status_r[0];
    view[0][msal_pkg::CHAIN_ONE_BIT] = |view[1];
  end

  // ---------------------------------------------------------------
  // Host register access
  // ---------------------------------------------------------------
  always_comb begin
    cfg_one_nxt  = cfg_one_r;
    cfg_thr_nxt  = cfg_thr_r;
    cfg_four_nxt = cfg_four_r;
    mask_nxt     = mask_r;
    rdata_nxt    = rdata_r;
    if (reg_req_in.wr) begin
      unique case (reg_req_in.addr)
        msal_pkg::CFG_ONE_ADDR:  cfg_one_nxt  = reg_req_in.wdata;
        msal_pkg::CFG_THR_ADDR:  cfg_thr_nxt  = reg_req_in.wdata;
        msal_pkg::CFG_FOUR_ADDR: cfg_four_nxt = reg_req_in.wdata;
        msal_pkg::MASK_ONE_ADDR: mask_nxt[0]  = reg_req_in.wdata;
        msal_pkg::MASK_TWO_ADDR: mask_nxt[1]  = reg_req_in.wdata;
        msal_pkg::MASK_THR_ADDR: mask_nxt[2]  = reg_req_in.wdata;
        msal_pkg::MASK_FOU_ADDR: mask_nxt[3]  = reg_req_in.wdata;
        default: ;
      endcase
    end
    if (reg_req_in.rd) begin
      rdata_nxt = 8'h00;
      unique case (reg_req_in.addr)
        msal_pkg::CFG_ONE_ADDR:    rdata_nxt = cfg_one_r;
        msal_pkg::CFG_THR_ADDR:    rdata_nxt = cfg_thr_r;
        msal_pkg::CFG_FOUR_ADDR:   rdata_nxt = cfg_four_r;
        msal_pkg::STATUS_ONE_ADDR: rdata_nxt = view[0];
        msal_pkg::STATUS_TWO_ADDR: rdata_nxt = view[1];
        msal_pkg::STATUS_THR_ADDR: rdata_nxt = view[2];
        msal_pkg::STATUS_FOU_ADDR: rdata_nxt = view[3];
        msal_pkg::MASK_ONE_ADDR:   rdata_nxt = mask_r[0];
        msal_pkg::MASK_TWO_ADDR:   rdata_nxt = mask_r[1];
        msal_pkg::MASK_THR_ADDR:   rdata_nxt = mask_r[2];
        msal_pkg::MASK_FOU_ADDR:   rdata_nxt = mask_r[3];
        default: begin
          if (reg_req_in.addr >= msal_pkg::VALUE_BASE_ADDR &&
              reg_req_in.addr <= msal_pkg::VALUE_BASE_ADDR +
                                 8'(msal_pkg::LAST_CHANNEL)) begin
            rdata_nxt = value_r[4'(reg_req_in.addr -
                                   msal_pkg::VALUE_BASE_ADDR)];
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      cfg_one_r  <= msal_pkg::CFG_ONE_RESET;
      cfg_thr_r  <= msal_pkg::CFG_THR_RESET;
      cfg_four_r <= msal_pkg::CFG_FOUR_RESET;
      rdata_r    <= 8'h00;
      for (int i = 0; i < 4; i++) begin
        mask_r[i] <= msal_pkg::MASK_RESET;
      end
    end else begin
      cfg_one_r  <= cfg_one_nxt;
      cfg_thr_r  <= cfg_thr_nxt;
      cfg_four_r <= cfg_four_nxt;
      rdata_r    <= rdata_nxt;
      mask_r     <= mask_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Alert and pin functions
  // ---------------------------------------------------------------
  always_comb begin
    alert = 1'b0;
    for (int i = 0; i < 4; i++) begin
      alert = alert |
              |(status_r[i] & ~mask_r[i] & src_mask[i]);
    end
    if (cfg_thr_r[msal_pkg::PIN10_ALERT_BIT]) begin
      p10_nxt    = 1'b0;
      p10_oe_nxt = alert;
    end else begin
      p10_nxt    = fan_drive_two_in;
      p10_oe_nxt = 1'b1;
    end
    p14_oe_nxt = (cfg_four_r[1:0] == msal_pkg::PIN14_ALERT_CODE) &&
                 alert;
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      p10_r    <= 1'b0;
      p10_oe_r <= 1'b0;
      p14_oe_r <= 1'b0;
    end else begin
      p10_r    <= p10_nxt;
      p10_oe_r <= p10_oe_nxt;
      p14_oe_r <= p14_oe_nxt;
    end
  end

  assign reg_rdata_out   = rdata_r;
  assign channel_sel_out = chan_r;
  assign single_channel_select_done_out   = done_r;
  assign pin10_out       = p10_r;
  assign pin10_oe_out    = p10_oe_r;
  assign pin14_out       = 1'b0;
  assign pin14_oe_out    = p14_oe_r;

endmodule // msal_monitor_status_alert
`default_nettype wire

// [verif/msal_monitor_status_alert_checker.sv]
`timescale 1ns/1ns
`default_nettype none
module msal_monitor_status_alert_checker #(
  parameter int VOLT_CYCLES   = 20,
  parameter int LOCAL_CYCLES  = 24,
  parameter int REMOTE_CYCLES = 40
) (
  input wire logic                       clock_in,
  input wire logic                       srst_in,
  input wire msal_pkg::msal_reg_req_type reg_req_in,
  input wire logic [7:0]                 reg_rdata_out,
  input wire logic                       fan_drive_two_in,
  input wire logic [3:0]                 channel_sel_out,
  input wire logic                       single_channel_select_done_out,
  input wire logic                       pin10_out,
  input wire logic                       pin10_oe_out,
  input wire logic                       pin14_oe_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (srst_in);
  logic       run_r, run_nxt, alt_r, alt_nxt, seen_r, seen_nxt, mapped;
  logic [1:0] p14_r, p14_nxt;
  logic [3:0] mf_r, mf_nxt, prv;
  int         gap_r, gap_nxt, want;
  // Shadow of config writes and gap between conversions
  always_comb begin
    run_nxt = run_r;
    alt_nxt = alt_r;
    p14_nxt = p14_r;
    mf_nxt  = mf_r;
    if (reg_req_in.wr) begin
      case (reg_req_in.addr)
        8'h40: run_nxt = reg_req_in.wdata[0];
        8'h78: alt_nxt = reg_req_in.wdata[0];
        8'h7D: p14_nxt = reg_req_in.wdata[1:0];
        8'h74: mf_nxt[0] = &reg_req_in.wdata;
        8'h75: mf_nxt[1] = &reg_req_in.wdata;
        8'h82: mf_nxt[2] = &reg_req_in.wdata;
        8'h83: mf_nxt[3] = &reg_req_in.wdata;
        default: ;
      endcase
    end
    gap_nxt  = single_channel_select_done_out ? 1 : (run_r ? gap_r + 1 : 0);
    seen_nxt = single_channel_select_done_out | (run_r & seen_r);
    prv      = (channel_sel_out == 4'h0) ? 4'h9 : channel_sel_out - 4'h1;
    want     = (prv == 4'h7) ? LOCAL_CYCLES :
               ((prv > 4'h7) ? REMOTE_CYCLES : VOLT_CYCLES);
    mapped   = reg_req_in.addr inside {[8'h20:8'h29], [8'h40:8'h43],
               8'h74, 8'h75, 8'h78, 8'h7D, [8'h81:8'h83]};
  end
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      {run_r, alt_r, seen_r, p14_r, mf_r} <= '0;
      gap_r <= 0;
    end else begin
      {run_r, alt_r, seen_r, p14_r, mf_r} <=
        {run_nxt, alt_nxt, seen_nxt, p14_nxt, mf_nxt};
      gap_r <= gap_nxt;
    end
  end
  a_unmapped_read: assert property (reg_req_in.rd && !mapped |=>
    reg_rdata_out == 8'h00) else $error("unmapped read not zero");
  a_rdata_holds: assert property (!$past(reg_req_in.rd) |->
    $stable(reg_rdata_out)) else $error("read data moved");
  a_chan_order: assert property ($changed(channel_sel_out) |->
    channel_sel_out == 4'h0 ||
    channel_sel_out == $past(channel_sel_out) + 4'h1)
    else $error("channel order broken");
  a_single_channel_select_time: assert property (single_channel_select_done_out && seen_r |->
    gap_r == want) else $error("conversion length wrong");
  a_run_progress: assert property (run_r |->
    gap_r <= REMOTE_CYCLES + 4) else $error("round-robin stalled");
  a_stop_idle: assert property (!run_r && !$past(run_r) &&
    !$past(run_r, 2) |-> channel_sel_out == 4'h0 && !single_channel_select_done_out)
    else $error("runs while stopped");
  a_pin10_pwm: assert property (!alt_r && !$past(alt_r) &&
    !$past(srst_in) && !$past(srst_in, 2) |-> pin10_oe_out &&
    pin10_out == $past(fan_drive_two_in)) else $error("pin10 not fan");
  a_alert_low: assert property (alt_r && $past(alt_r) |->
    !pin10_out) else $error("alert pin driven high");
  a_alert_masked: assert property (&mf_r && &$past(mf_r) |->
    !pin14_oe_out && !(alt_r && $past(alt_r) && pin10_oe_out))
    else $error("masked source drives alert");
  a_pin14_select: assert property (pin14_oe_out |->
    p14_r == 2'h2 || $past(p14_r) == 2'h2) else $error("pin14 misused");
endmodule // msal_monitor_status_alert_checker
`default_nettype wire

// [verif/msal_host_model.sv]
`timescale 1ns/1ns
`default_nettype none
module msal_host_model (
  input  wire logic                      clock_in,
  input  wire logic [7:0]                reg_rdata_in,
  output var msal_pkg::msal_reg_req_type reg_req_out
);
  initial reg_req_out = '0;
  // Released bus shows inverted leftovers, never stale values
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock_in);
    reg_req_out = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(negedge clock_in);
    reg_req_out = '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
  endtask
  // Status polling by register read
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock_in);
    reg_req_out = '{addr: a, wr: 1'b0, rd: 1'b1,
                    wdata: ~reg_req_out.wdata};
    @(negedge clock_in);
    d = reg_rdata_in;
    reg_req_out = '{addr: ~a, wr: 1'b0, rd: 1'b0,
                    wdata: ~reg_req_out.wdata};
  endtask
endmodule // msal_host_model
`default_nettype wire

// [verif/tb_msal_monitor_status_alert.sv]
`timescale 1ns/1ns
`default_nettype none
module tb_msal_monitor_status_alert;
  localparam int VC = 20;
  localparam int LC = 24;
  localparam int RC = 40;
  localparam int RND = 7 * VC + LC + 2 * RC + 8;
  logic                       clk = 1'b0;
  logic                       srst = 1'b1;
  logic                       fan2 = 1'b0;
  logic                       m, p10, p10oe, p14, p14oe, done;
  msal_pkg::msal_reg_req_type req;
  msal_pkg::msal_ext_type     ext = '0;
  logic [7:0]                 rdata, rv, a, b, ua, ub;
  logic [7:0]                 meas = 8'h80;
  logic [7:0]                 hi = 8'hF0;
  logic [7:0]                 lo = 8'h10;
  logic [7:0]                 tab [10];
  logic [7:0]                 rl [13] = '{8'h40, 8'h41, 8'h42, 8'h43,
    8'h74, 8'h75, 8'h78, 8'h7D, 8'h81, 8'h82, 8'h83, 8'h25, 8'h3C};
  logic [7:0]                 ms [4] = '{8'h74, 8'h75, 8'h82, 8'h83};
  logic [7:0]                 st [4] = '{8'h41, 8'h42, 8'h43, 8'h81};
  logic [3:0]                 ch;
  logic [31:0]                seed = 32'h0001_1013;
  int                         errors = 0;
  int                         checked = 0;
  int                         cycles = 0;

  always #2 clk = ~clk;
  msal_host_model i_host (.clock_in(clk), .reg_rdata_in(rdata),
    .reg_req_out(req));
  msal_monitor_status_alert #(.VOLT_CYCLES(VC), .LOCAL_CYCLES(LC),
    .REMOTE_CYCLES(RC)) i_dut (.clock_in(clk), .srst_in(srst),
    .reg_req_in(req), .reg_rdata_out(rdata), .meas_value_in(meas),
    .limit_high_in(hi), .limit_low_in(lo), .ext_flags_in(ext),
    .fan_drive_two_in(fan2), .channel_sel_out(ch),
    .single_channel_select_done_out(done), .pin10_out(p10), .pin10_oe_out(p10oe),
    .pin14_out(p14), .pin14_oe_out(p14oe));

  always @(negedge clk) begin
    fan2 <= ~fan2;
    if ((ch < 4'hA) === 1'b1) meas <= tab[ch];
    else meas <= 8'h80;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      errors = errors + 1;
      final_report();
    end
  end

  function automatic logic [7:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  function automatic logic oor(input logic [7:0] v);
    return (v > hi) || (v <= lo);
  endfunction
  task automatic check(input logic [7:0] s, input logic [7:0] e,
                       input logic [7:0] c);
    checked++;
    if ((s & c) !== (e & c)) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic final_report();
    $display("Comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    foreach (tab[i]) tab[i] = 8'h80;
    repeat (4) @(posedge clk);
    @(negedge clk) srst = 1'b0;
    foreach (rl[i]) begin
      i_host.rd_reg(rl[i], rv);
      check(rv, 8'h00, 8'hFF);
    end
    check({6'h0, p14oe, p10oe}, 8'h01, 8'h03);
    foreach (ms[i]) begin
      b = xs();
      i_host.wr_reg(ms[i], b);
      i_host.rd_reg(ms[i], rv);
      check(rv, b, 8'hFF);
      i_host.wr_reg(ms[i], 8'h00);
    end
    i_host.wr_reg(8'h78, 8'h01);
    for (int i = 0; i < 13; i++) begin
      a = (i < 3) ? 8'h81 : ((i < 7) ? 8'h43 : 8'h42);
      b = 8'h01 << ((i < 3) ? i + 3 : ((i < 7) ? i - 3 : i - 5));
      ua = (a == 8'h42) ? 8'h41 : ((a == 8'h43) ? 8'h42 : 8'h43);
      ub = (a == 8'h43) ? 8'h02 : 8'h80;
      rv = xs();
      m = rv[0];
      i_host.wr_reg((a == 8'h81) ? 8'h83 : ((a == 8'h43) ? 8'h82 : 8'h75),
                    m ? b : 8'h00);
      @(negedge clk) ext = msal_pkg::msal_ext_type'(13'h1 << i);
      repeat (3) @(negedge clk);
      check({7'h0, p10oe}, {7'h0, !m}, 8'h01);
      i_host.rd_reg(ua, rv);
      check(rv, ub, ub);
      ext = '0;
      repeat (3) @(negedge clk);
      check({7'h0, p10oe}, {7'h0, !m}, 8'h01);
      i_host.rd_reg(a, rv);
      check(rv, b, b);
      i_host.rd_reg(a, rv);
      check(rv, 8'h00, b);
      check({7'h0, p10oe}, 8'h00, 8'h01);
    end
    foreach (tab[c]) tab[c] = xs();
    tab[0] = lo;
    tab[1] = lo + 8'h01;
    tab[2] = hi;
    tab[3] = hi + 8'h01;
    i_host.wr_reg(8'h40, 8'h01);
    repeat (RND) @(negedge clk);
    foreach (ms[i]) i_host.wr_reg(ms[i], 8'hFF);
    repeat (3) @(negedge clk);
    check({7'h0, p10oe}, 8'h00, 8'h01);
    i_host.rd_reg(8'h41, rv);
    check(rv, {1'b0, oor(tab[9]), oor(tab[7]), oor(tab[8]), oor(tab[3]),
      oor(tab[2]), oor(tab[1]), oor(tab[0])}, 8'h7F);
    i_host.rd_reg(8'h42, rv);
    check(rv, {7'h0, oor(tab[4])}, 8'h01);
    i_host.rd_reg(8'h81, rv);
    check(rv, {oor(tab[5]), oor(tab[6]), 6'h0}, 8'hC0);
    foreach (tab[c]) begin
      i_host.rd_reg(8'(32'h20 + c), rv);
      check(rv, tab[c], 8'hFF);
    end
    i_host.wr_reg(8'h40, 8'h00);
    repeat (RC) @(negedge clk);
    check({4'h0, ch}, 8'h00, 8'hFF);
    foreach (tab[c]) tab[c] = 8'h80;
    i_host.wr_reg(8'h40, 8'h01);
    repeat (RND) @(negedge clk);
    foreach (st[i]) i_host.rd_reg(st[i], rv);
    foreach (st[i]) begin
      i_host.rd_reg(st[i], rv);
      check(rv, 8'h00, 8'hFF);
    end
    i_host.wr_reg(8'h75, 8'h00);
    ext.fan_one = 1'b1;
    for (int k = 0; k < 4; k++) begin
      i_host.wr_reg(8'h7D, 8'(k));
      repeat (3) @(negedge clk);
      check({7'h0, p14oe}, {7'h0, k == 2}, 8'h01);
      check({7'h0, p14}, 8'h00, 8'h01);
    end
    ext = '0;
    i_host.wr_reg(8'h78, 8'h00);
    repeat (3) @(negedge clk);
    check({6'h0, p10, p10oe}, {6'h0, fan2, 1'b1}, 8'h03);
    @(negedge clk);
    check({6'h0, p10, p10oe}, {6'h0, fan2, 1'b1}, 8'h03);
    final_report();
  end
endmodule // tb_msal_monitor_status_alert

bind msal_monitor_status_alert msal_monitor_status_alert_checker #(
  .VOLT_CYCLES(VOLT_CYCLES), .LOCAL_CYCLES(LOCAL_CYCLES),
  .REMOTE_CYCLES(REMOTE_CYCLES)) i_chk (.clock_in(clock_in),
  .srst_in(srst_in), .reg_req_in(reg_req_in),
  .reg_rdata_out(reg_rdata_out), .fan_drive_two_in(fan_drive_two_in),
  .channel_sel_out(channel_sel_out), .single_channel_select_done_out(single_channel_select_done_out),
  .pin10_out(pin10_out), .pin10_oe_out(pin10_oe_out),
  .pin14_oe_out(pin14_oe_out));
`default_nettype wire
